// ---- common/bssc_pkg.sv ----
// constants and types for the burst synchronous sram control block
`default_nettype none

package bssc_pkg;

  // array geometry
  localparam int unsigned BSSC_AW = 16;
  localparam int unsigned BSSC_DW = 18;
  localparam int unsigned BSSC_LO_W = 9;
  localparam int unsigned BSSC_DEPTH = 65536;

  // burst counter on the two low address bits
  localparam int unsigned BSSC_CNT_W = 2;
  localparam logic [1:0] BSSC_CNT_ZERO = 2'h0;
  localparam logic [1:0] BSSC_CNT_STEP = 2'h1;

  // reset value of the read data register
  localparam logic [17:0] BSSC_DATA_RST = 18'h0_0000;

  // kind of array access decided for a sampled cycle
  typedef enum logic [2:0]
  {
    BSSC_OP_NONE  = 3'b001,
    BSSC_OP_READ  = 3'b010,
    BSSC_OP_WRITE = 3'b100
  } bssc_op_t;

  // one clock's image of the synchronous pins
  typedef struct packed
  {
    logic chip_sel_n;
    logic proc_addr_strobe_n;
    logic ctrl_addr_strobe_n;
    logic burst_step_n;
    logic lo_byte_wr_n;
    logic hi_byte_wr_n;
    logic [BSSC_AW-1:0] addr;
    logic [BSSC_DW-1:0] data;
  } bssc_pins_t;

  // all strobes and enables idle high after reset
  localparam bssc_pins_t BSSC_PINS_IDLE = '1;

endpackage : bssc_pkg

`default_nettype wire

// ---- rtl/bssc_sram.sv ----
// burst synchronous static memory with self-timed byte writes
`timescale 1ns/100ps
`default_nettype none

module bssc_sram
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,

  // address and burst control
  input wire logic [bssc_pkg::BSSC_AW-1:0] addr_in,
  input wire logic chip_sel_n,
  input wire logic proc_addr_strobe_n,
  input wire logic ctrl_addr_strobe_n,
  input wire logic burst_step_n,

  // byte write enables
  input wire logic lo_byte_wr_n,
  input wire logic hi_byte_wr_n,

  // asynchronous output enable
  input wire logic out_en_n,

  // shared data pins, split into three signals
  input wire logic [bssc_pkg::BSSC_DW-1:0] data_in,
  output logic [bssc_pkg::BSSC_DW-1:0] data_out,
  output logic data_oe_n
);

  import bssc_pkg::*;

  // counter step with natural wrap of two bits
  function automatic logic [BSSC_CNT_W-1:0] step_cnt
  (
    input logic [BSSC_CNT_W-1:0] cnt
  );
    step_cnt = cnt + BSSC_CNT_STEP;
  endfunction : step_cnt

  // interleaved burst address from base and count
  function automatic logic [BSSC_AW-1:0] burst_addr
  (
    input logic [BSSC_AW-1:0] base,
    input logic [BSSC_CNT_W-1:0] cnt
  );
    burst_addr = base;
    burst_addr[BSSC_CNT_W-1:0] = base[BSSC_CNT_W-1:0] ^ cnt;
  endfunction : burst_addr

  // merge new data into a stored word per byte lane
  function automatic logic [BSSC_DW-1:0] merge_bytes
  (
    input logic [BSSC_DW-1:0] old_word,
    input logic [BSSC_DW-1:0] new_word,
    input logic lo_n,
    input logic hi_n
  );
    merge_bytes = old_word;
    if (!lo_n)
    begin
      merge_bytes[BSSC_LO_W-1:0] = new_word[BSSC_LO_W-1:0];
    end
    if (!hi_n)
    begin
      merge_bytes[BSSC_DW-1:BSSC_LO_W] =
        new_word[BSSC_DW-1:BSSC_LO_W];
    end
  endfunction : merge_bytes

  // storage array
  logic [BSSC_DW-1:0] mem [0:BSSC_DEPTH-1];

  // sampled pins
  bssc_pins_t smp;
  bssc_pins_t next_smp;

  // burst state
  logic [BSSC_AW-1:0] base;
  logic [BSSC_CNT_W-1:0] cnt;
  logic selected;
  logic rd_drive;

  // decode of the sampled cycle
  logic load_proc;
  logic load_ctrl;
  logic load;
  logic any_wr;
  bssc_op_t op;
  logic [BSSC_AW-1:0] next_base;
  logic [BSSC_CNT_W-1:0] next_cnt;
  logic next_selected;
  logic [BSSC_AW-1:0] acc_addr;

  // pack the pins; the far end shares clk, so one stage
  always_comb
  begin
    next_smp.chip_sel_n = chip_sel_n;
    next_smp.proc_addr_strobe_n = proc_addr_strobe_n;
    next_smp.ctrl_addr_strobe_n = ctrl_addr_strobe_n;
    next_smp.burst_step_n = burst_step_n;
    next_smp.lo_byte_wr_n = lo_byte_wr_n;
    next_smp.hi_byte_wr_n = hi_byte_wr_n;
    next_smp.addr = addr_in;
    next_smp.data = data_in;
  end

  // input registers, output enable excluded
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      smp <= BSSC_PINS_IDLE;
    end
    else
    begin
      smp <= next_smp;
    end
  end

  // which strobe starts a burst
  always_comb
  begin
    load_proc = ~smp.proc_addr_strobe_n;
    load_ctrl = smp.proc_addr_strobe_n
      & ~smp.ctrl_addr_strobe_n;
    load = load_proc | load_ctrl;
    any_wr = ~smp.lo_byte_wr_n | ~smp.hi_byte_wr_n;
  end

  // access kind of the sampled cycle
  always_comb
  begin
    op = BSSC_OP_NONE;
    if (load)
    begin
      if (smp.chip_sel_n)
      begin
        op = BSSC_OP_NONE;
      end
      else if (load_proc)
      begin
        // write enables ignored on a processor load
        op = BSSC_OP_READ;
      end
      else if (any_wr)
      begin
        op = BSSC_OP_WRITE;
      end
      else
      begin
        op = BSSC_OP_READ;
      end
    end
    else if (selected)
    begin
      // second cycle of a processor write lands here
      if (any_wr)
      begin
        op = BSSC_OP_WRITE;
      end
      else
      begin
        op = BSSC_OP_READ;
      end
    end
  end

  // burst address sequencing
  always_comb
  begin
    next_base = base;
    next_cnt = cnt;
    next_selected = selected;
    if (load)
    begin
      next_selected = ~smp.chip_sel_n;
      next_cnt = BSSC_CNT_ZERO;
      if (!smp.chip_sel_n)
      begin
        next_base = smp.addr;
      end
    end
    else if (!smp.burst_step_n)
    begin
      next_cnt = step_cnt(cnt);
    end
    else
    begin
      next_cnt = cnt;
    end
  end

  // address actually used this cycle
  always_comb
  begin
    if (load)
    begin
      acc_addr = smp.addr;
    end
    else
    begin
      acc_addr = burst_addr(base, next_cnt);
    end
  end

  // burst state registers
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      base <= '0;
      cnt <= BSSC_CNT_ZERO;
      selected <= 1'b0;
    end
    else
    begin
      base <= next_base;
      cnt <= next_cnt;
      selected <= next_selected;
    end
  end

  // write completes within one clock, no external pulse
  // array is not reset, so its contents are unknown at start
  always_ff @(posedge clk)
  begin
    if (op == BSSC_OP_WRITE)
    begin
      mem[acc_addr] <= merge_bytes(mem[acc_addr], smp.data,
        smp.lo_byte_wr_n, smp.hi_byte_wr_n);
    end
  end

  // read data register
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      data_out <= BSSC_DATA_RST;
    end
    else if (op == BSSC_OP_READ)
    begin
      data_out <= mem[acc_addr];
    end
  end

  // drivers allowed only after a read; writes and
  // deselects clear it so the pins float
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rd_drive <= 1'b0;
    end
    else
    begin
      rd_drive <= (op == BSSC_OP_READ);
    end
  end

  // output enable bypasses the clock; master keeps it
  // high around a write that follows a read
  assign data_oe_n = ~(rd_drive & ~out_en_n);

endmodule : bssc_sram

`default_nettype wire

// ---- tb/bssc_sram_monitor.sv ----
// pin-level assertions for the burst sram control block
`timescale 1ns/100ps
`default_nettype none
module bssc_sram_monitor
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // synchronous controls
  input wire logic chip_sel_n,
  input wire logic proc_addr_strobe_n,
  input wire logic ctrl_addr_strobe_n,
  input wire logic burst_step_n,
  input wire logic lo_byte_wr_n,
  input wire logic hi_byte_wr_n,
  // data side
  input wire logic out_en_n,
  input wire logic [17:0] data_out,
  input wire logic data_oe_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire ld = !proc_addr_strobe_n || !ctrl_addr_strobe_n;
  wire wr = !lo_byte_wr_n || !hi_byte_wr_n;
  wire cont = proc_addr_strobe_n && ctrl_addr_strobe_n;
  chk_oe_float: assert property (out_en_n |-> data_oe_n)
    else $error("pins driven with output enable high");
  // pins register at one edge, decode drives rd_drive at the next
  chk_desel_float: assert property
    (ld && chip_sel_n |-> ##2 data_oe_n)
    else $error("pins driven after deselecting load");
  chk_write_float: assert property
    (proc_addr_strobe_n && wr |-> ##2 data_oe_n)
    else $error("pins driven during write");
  chk_proc_read: assert property
    (!chip_sel_n && !proc_addr_strobe_n ##2 !out_en_n |-> !data_oe_n)
    else $error("processor load did not read");
  chk_ctrl_read: assert property
    (!chip_sel_n && proc_addr_strobe_n && !ctrl_addr_strobe_n && !wr
     ##2 !out_en_n |-> !data_oe_n)
    else $error("controller load did not read");
  chk_hold_repeat: assert property
    (cont && burst_step_n && !wr ##1 !data_oe_n ##1 !out_en_n
     |-> !data_oe_n && $stable(data_out))
    else $error("suspended read changed data");
  chk_reset_float: assert property
    ($past(rst) |-> data_oe_n && data_out == 18'h0_0000)
    else $error("pins not floating after reset");
  chk_data_hold: assert property
    (!$stable(data_out) && !out_en_n |-> !data_oe_n)
    else $error("read data changed without a read");
endmodule : bssc_sram_monitor
bind bssc_sram bssc_sram_monitor mon (.*);
`default_nettype wire

// ---- tb/bssc_host.sv ----
// far-side bus master: output enable and shared data wire
`timescale 1ns/100ps
`default_nettype none
module bssc_host
(
  // clock
  input wire logic clk,
  // master side
  input wire logic drv,
  input wire logic oe_req_n,
  input wire logic [17:0] wd,
  // memory side
  input wire logic [17:0] q,
  input wire logic q_oe_n,
  output logic out_en_n,
  output logic [17:0] bus
);
  logic [17:0] last = 18'h0_0000;
  // master never enables outputs while it drives write data
  assign out_en_n = oe_req_n | drv;
  // undriven wire shows inverted last value, not a stale copy
  assign bus = !q_oe_n ? q : drv ? wd : ~last;
  always_ff @(posedge clk) last <= bus;
endmodule : bssc_host
`default_nettype wire

// ---- tb/bssc_sram_tb.sv ----
// self-checking bench for the burst sram control block
`timescale 1ns/100ps
`default_nettype none
module bssc_sram_tb;
  logic clk = 0, rst = 1, oe_req_n = 0, drv = 0, oe_n, q_oe_n;
  logic [17:0] q, bus;
  logic [40:0] r;
  bssc_pkg::bssc_pins_t p = bssc_pkg::BSSC_PINS_IDLE;
  int err_total = 0, n_tests = 0;
  // expect float, controls, address, write data or read data
  logic [40:0] rows [16] = '{
    {1'b1,6'h14,16'h1234,18'h0_1111}, {1'b1,6'h18,16'h0000,18'h0_2222},
    {1'b1,6'h18,16'h0000,18'h0_3333}, {1'b1,6'h18,16'h0000,18'h0_4444},
    {1'b0,6'h0f,16'h1235,18'h0_2222}, {1'b0,6'h1b,16'h0000,18'h0_1111},
    {1'b0,6'h1f,16'h0000,18'h0_1111}, {1'b0,6'h1b,16'h0000,18'h0_4444},
    {1'b0,6'h1b,16'h0000,18'h0_3333}, {1'b0,6'h1b,16'h0000,18'h0_2222},
    {1'b0,6'h17,16'h1236,18'h0_3333}, {1'b0,6'h04,16'h1237,18'h0_4444},
    {1'b1,6'h1e,16'h0000,18'h3_ffff}, {1'b1,6'h37,16'h1237,18'h0_0000},
    {1'b1,6'h1b,16'h0000,18'h0_0000}, {1'b0,6'h0f,16'h1237,18'h3_fe44}};
  always #4 clk = ~clk;
  bssc_sram DUT (.clk(clk), .rst(rst), .addr_in(p.addr),
    .chip_sel_n(p.chip_sel_n), .proc_addr_strobe_n(p.proc_addr_strobe_n),
    .ctrl_addr_strobe_n(p.ctrl_addr_strobe_n),
    .burst_step_n(p.burst_step_n), .lo_byte_wr_n(p.lo_byte_wr_n),
    .hi_byte_wr_n(p.hi_byte_wr_n), .out_en_n(oe_n), .data_in(bus),
    .data_out(q), .data_oe_n(q_oe_n));
  bssc_host host (.clk(clk), .drv(drv), .oe_req_n(oe_req_n), .wd(p.data),
    .q(q), .q_oe_n(q_oe_n), .out_en_n(oe_n), .bus(bus));
  task chk(string n, logic [18:0] s, logic [18:0] e);
    n_tests++;
    if (s !== e)
    begin
      err_total++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task results;
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : results
  initial
  begin
    #3000;
    err_total++;
    results();
  end
  initial
  begin
    repeat (10) @(posedge clk);
    #1 rst = 0;
    chk("pwrup", 19'(q_oe_n), 19'h1);
    for (int i = 0; i <= 17; i++)
    begin
      @(posedge clk) #1;
      // a row shows on the pins two edges after it is applied
      if (i > 1)
      begin
        r = rows[i-2];
        // master keeps enable high while it drives write data
        chk("oe", 19'(q_oe_n), 19'(r[40] | drv));
        if (!r[40]) chk("rd", 19'(q), 19'(r[17:0]));
      end
      if (i < 16)
      begin
        p = rows[i][39:0];
        drv = p.proc_addr_strobe_n & ~(p.lo_byte_wr_n & p.hi_byte_wr_n);
      end
    end
    $display("table test done");
    // repeat last read with enable high, then enable with no clock edge
    oe_req_n = 1;
    @(posedge clk) #1;
    chk("float", 19'(q_oe_n), 19'h1);
    oe_req_n = 0;
    #1 chk("async", {q_oe_n, q}, 19'h3_fe44);
    $display("output enable test done");
    @(posedge clk) #1 rst = 1;
    #1 chk("rst", {q_oe_n, q}, 19'h4_0000);
    p = bssc_pkg::BSSC_PINS_IDLE;
    repeat (3) @(posedge clk);
    #1 rst = 0;
    @(posedge clk) #1;
    chk("rerst", 19'(q_oe_n), 19'h1);
    $display("reset test done");
    results();
  end
endmodule : bssc_sram_tb
`default_nettype wire
